// ===== include/gpsp_pkg.sv
`default_nettype none

package gpsp_pkg;

    // ------------------------------------------------------------
    // pin map
    // ------------------------------------------------------------
    // pins grouped by port; port_d sits in the top bits
    typedef struct packed {
        logic [5:0] port_d;
        logic [3:0] port_zero;
        logic [3:0] port_one;
        logic [1:0] port_two;
        logic [1:0] port_three;
    } gpsp_pins_t;

    localparam int PIN_W = 18;
    localparam int PORTD_BASE = 12;
    localparam int SHARED_PORTD_LINE_A = 14;
    localparam int SHARED_PORTD_LINE_B = 15;
    localparam int PORT1_BIT2_TIMER_PIN = 6;
    localparam int PORT1_BIT3_IRQ_PIN = 7;
    localparam int ANALOG_IN_0 = 2;
    localparam int ANALOG_IN_1 = 3;
    localparam int ANALOG_IN_2 = 0;
    localparam int ANALOG_IN_3 = 1;
    localparam int ANALOG_N = 4;
    localparam int ANALOG_PIN [ANALOG_N] = '{ANALOG_IN_0, ANALOG_IN_1, ANALOG_IN_2, ANALOG_IN_3};

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_LATCH_OFS = 8'h00;
    localparam logic [7:0] REG_PIN_LEVEL_OFS = 8'h04;
    localparam logic [7:0] REG_PULLUP_OFS = 8'h08;
    localparam logic [7:0] REG_ALT_SEL_OFS = 8'h0C;
    localparam logic [7:0] REG_IRQ_CONTROL_OFS = 8'h10;
    localparam logic [7:0] REG_WAKE_EN_OFS = 8'h14;
    localparam logic [7:0] REG_BACKUP_OFS = 8'h18;
    localparam logic [7:0] REG_BIT_OP_OFS = 8'h1C;

    // values after reset
    localparam logic [17:0] LATCH_RST = 18'h3FFFF;
    localparam logic [17:0] PULLUP_RST = 18'h00000;
    localparam logic [17:0] WAKE_EN_RST = 18'h00000;
    localparam logic [7:0] ALT_SEL_RST = 8'h00;
    localparam logic [3:0] IRQ_CONTROL_RST = 4'h0;
    localparam logic [17:0] SYNC_RST = 18'h3FFFF;

    // field positions
    localparam int ALT_CLK_PAIR = 0;
    localparam int ALT_TIMER_IN = 1;
    localparam int ALT_TIMER_OUT = 2;
    localparam int ALT_ANALOG_LSB = 4;
    localparam int IRQ_INPUT_GATE_BIT = 3;
    localparam int BACKUP_ENTER_BIT = 0;
    localparam int BACKUP_WOKE_BIT = 1;
    localparam int BIT_OP_SET_BIT = 4;
    localparam logic [3:0] PORTD_IDX_LIMIT = 4'h6;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // byte-lane merge of a write into an old value
    function automatic logic [31:0] gpsp_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return (old_val & ~m) | (new_val & m);
    endfunction

endpackage

`default_nettype wire

// ===== rtl/gpsp_sync.sv
`default_nettype none

module gpsp_sync #(
    parameter int WIDTH = 18,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import gpsp_pkg::*;

    // ------------------------------------------------------------
    // two-stage synchroniser, one per pin
    // ------------------------------------------------------------
    for (genvar g = 0; g < WIDTH; g++)
    begin : g_bit
        logic meta_q;
        logic stable_q;
        // first stage feeds only the second
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                meta_q <= RST_VAL[g];
                stable_q <= RST_VAL[g];
            end
            else
            begin
                meta_q <= async_in[g];
                stable_q <= meta_q;
            end
        end
        assign sync_out[g] = stable_q;
    end

endmodule

`default_nettype wire

// ===== rtl/gpsp_axil_slave.sv
`default_nettype none

module gpsp_axil_slave #(
    parameter int AW = gpsp_pkg::ADDR_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [AW-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [AW-1:0] rd_addr,
    output logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    import gpsp_pkg::*;

    logic have_aw_q;
    logic have_w_q;
    logic [AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    logic ar_hs;
    logic r_hs;
    logic have_aw_d;
    logic have_w_d;
    logic bvalid_d;

    // ------------------------------------------------------------
    // write channels
    // ------------------------------------------------------------
    // handshakes and next state of the write side
    assign aw_hs = s_axi_awvalid & awready_q;
    assign w_hs = s_axi_wvalid & wready_q;
    assign b_hs = bvalid_q & s_axi_bready;
    assign wr_en = have_aw_q & have_w_q;
    assign wr_addr = aw_addr_q;
    assign wr_data = w_data_q;
    assign wr_strb = w_strb_q;
    assign have_aw_d = wr_en ? 1'b0 : (have_aw_q | aw_hs);
    assign have_w_d = wr_en ? 1'b0 : (have_w_q | w_hs);
    assign bvalid_d = wr_en | (bvalid_q & ~s_axi_bready);

    // address and data are taken in either order, then committed
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end
        else
        begin
            have_aw_q <= have_aw_d;
            have_w_q <= have_w_d;
            awready_q <= ~have_aw_d & ~bvalid_d & ~wr_en;
            wready_q <= ~have_w_d & ~bvalid_d & ~wr_en;
            bvalid_q <= bvalid_d;
            if (aw_hs)
                aw_addr_q <= s_axi_awaddr;
            if (w_hs)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_en)
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // read channels
    // ------------------------------------------------------------
    // read data captured at the address handshake
    assign ar_hs = s_axi_arvalid & arready_q;
    assign r_hs = rvalid_q & s_axi_rready;
    assign rd_addr = s_axi_araddr;
    assign rd_en = ar_hs;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end
        else
        begin
            arready_q <= ~ar_hs & (~rvalid_q | s_axi_rready);
            if (ar_hs)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_ok ? rd_data : 32'h0000_0000;
                rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (r_hs)
                rvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

endmodule

`default_nettype wire

// ===== rtl/gpsp_shared_io.sv
// Notes on behaviour
// - a latch bit at zero drives its pin low, so the pin reads low whatever is outside.
// - the shared port D pair and port one bit three stay full ports under alt roles; bit two is also pulled low by a low timer output.
// - port one bit two stays readable while it carries the timer count output.
// - pins chosen as analog inputs keep their port two and three latches on the pin.
// - the port read of a pin chosen as analog input is masked and always reads zero.
// - bit three of the irq control register gates the irq pin, and resets to zero.
// - a wake-up enable left on a pin that reads low ends back-up right after entry.
`default_nettype none

module gpsp_shared_io (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [gpsp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [gpsp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire gpsp_pkg::gpsp_pins_t pins_in,
    output gpsp_pkg::gpsp_pins_t pins_out,
    output gpsp_pkg::gpsp_pins_t pins_oe_n,
    output gpsp_pkg::gpsp_pins_t pullup_en,
    input wire logic timer_out_val,
    output logic timer_count_in,
    output logic [1:0] clk_pair_in,
    output logic irq_pin_level,
    output logic [gpsp_pkg::ANALOG_N-1:0] analog_sel,
    output logic backup_active,
    output logic wake_pulse
);
    import gpsp_pkg::*;

    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [PIN_W-1:0] sync_pins;
    logic [PIN_W-1:0] latch_q;
    logic [PIN_W-1:0] pullup_q;
    logic [PIN_W-1:0] wake_en_q;
    logic [7:0] alt_q;
    logic [3:0] irq_ctl_q;
    logic [PIN_W-1:0] pin_level_q;
    logic [PIN_W-1:0] oe_n_q;
    logic [PIN_W-1:0] oe_n_d;
    logic [PIN_W-1:0] analog_mask;
    logic backup_q;
    logic woke_q;
    logic wake_pulse_q;
    logic wake_hit;
    logic timer_count_in_q;
    logic [1:0] clk_pair_q;
    logic irq_level_q;
    logic [ANALOG_N-1:0] analog_sel_q;
    logic bitop_hit;
    logic [3:0] bitop_idx;

    // ------------------------------------------------------------
    // bus slave and pin synchroniser
    // ------------------------------------------------------------
    gpsp_axil_slave #(.AW(ADDR_W)) u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_en(),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    gpsp_sync #(.WIDTH(PIN_W), .RST_VAL(SYNC_RST)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pins_in),
        .sync_out(sync_pins)
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    // write decode: every word of the map except the read-only level
    always_comb
    begin
        case (wr_addr)
            REG_LATCH_OFS, REG_PULLUP_OFS, REG_ALT_SEL_OFS, REG_IRQ_CONTROL_OFS,
            REG_WAKE_EN_OFS, REG_BACKUP_OFS, REG_BIT_OP_OFS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // read mux, narrow fields sit low
    always_comb
    begin
        rd_ok = 1'b1;
        case (rd_addr)
            REG_LATCH_OFS: rd_data = 32'(latch_q);
            REG_PIN_LEVEL_OFS: rd_data = 32'(pin_level_q);
            REG_PULLUP_OFS: rd_data = 32'(pullup_q);
            REG_ALT_SEL_OFS: rd_data = 32'(alt_q);
            REG_IRQ_CONTROL_OFS: rd_data = 32'(irq_ctl_q);
            REG_WAKE_EN_OFS: rd_data = 32'(wake_en_q);
            REG_BACKUP_OFS: rd_data = {30'h0000_0000, woke_q, backup_q};
            REG_BIT_OP_OFS: rd_data = 32'h0000_0000;
            default:
            begin
                rd_data = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // output latches
    // ------------------------------------------------------------
    // index at or above six is dropped
    assign bitop_idx = wr_data[3:0];
    assign bitop_hit = wr_en && (wr_addr == REG_BIT_OP_OFS) && wr_strb[0]
        && (bitop_idx < PORTD_IDX_LIMIT);

    // latches written whole or one port D bit at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            latch_q <= LATCH_RST;
        else if (wr_en && wr_addr == REG_LATCH_OFS)
            latch_q <= 18'(gpsp_merge(32'(latch_q), wr_data, wr_strb));
        else if (bitop_hit)
            latch_q[PORTD_BASE + int'(bitop_idx)] <= wr_data[BIT_OP_SET_BIT];
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // pull-ups, alternate roles, wake-up enables
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pullup_q <= PULLUP_RST;
            alt_q <= ALT_SEL_RST;
            wake_en_q <= WAKE_EN_RST;
        end
        else if (wr_en)
        begin
            if (wr_addr == REG_PULLUP_OFS)
                pullup_q <= 18'(gpsp_merge(32'(pullup_q), wr_data, wr_strb));
            if (wr_addr == REG_ALT_SEL_OFS && wr_strb[0])
                alt_q <= wr_data[7:0];
            if (wr_addr == REG_WAKE_EN_OFS)
                wake_en_q <= 18'(gpsp_merge(32'(wake_en_q), wr_data, wr_strb));
        end
    end

    // irq control, input gate off after reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_ctl_q <= IRQ_CONTROL_RST;
        else if (wr_en && wr_addr == REG_IRQ_CONTROL_OFS && wr_strb[0])
            irq_ctl_q <= wr_data[3:0];
    end

    // ------------------------------------------------------------
    // pin drive and pin read
    // ------------------------------------------------------------
    // open drain: a zero latch pulls low, alt roles never release it
    always_comb
    begin
        oe_n_d = latch_q;
        if (alt_q[ALT_TIMER_OUT] && !timer_out_val)
            oe_n_d[PORT1_BIT2_TIMER_PIN] = 1'b0;
    end

    // mask of pins serving as analog inputs
    for (genvar a = 0; a < PIN_W; a++)
    begin : g_amask
        logic hit;
        always_comb
        begin
            hit = 1'b0;
            for (int k = 0; k < ANALOG_N; k++)
            begin
                if (ANALOG_PIN[k] == a && alt_q[ALT_ANALOG_LSB + k])
                    hit = 1'b1;
            end
        end
        assign analog_mask[a] = hit;
    end

    // registered drive and sampled levels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            oe_n_q <= LATCH_RST;
            pin_level_q <= '0;
        end
        else
        begin
            oe_n_q <= oe_n_d;
            pin_level_q <= sync_pins & ~analog_mask;
        end
    end

    // alternate role inputs toward the core
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_count_in_q <= 1'b0;
            clk_pair_q <= 2'h0;
            irq_level_q <= 1'b0;
            analog_sel_q <= '0;
        end
        else
        begin
            timer_count_in_q <= alt_q[ALT_TIMER_IN] & sync_pins[PORT1_BIT2_TIMER_PIN];
            clk_pair_q <= alt_q[ALT_CLK_PAIR]
                ? {sync_pins[SHARED_PORTD_LINE_B], sync_pins[SHARED_PORTD_LINE_A]} : 2'h0;
            irq_level_q <= irq_ctl_q[IRQ_INPUT_GATE_BIT]
                & sync_pins[PORT1_BIT3_IRQ_PIN];
            analog_sel_q <= alt_q[ALT_ANALOG_LSB +: ANALOG_N];
        end
    end

    // ------------------------------------------------------------
    // back-up mode and key wake-up
    // ------------------------------------------------------------
    // any enabled pin at low level wakes the part
    assign wake_hit = |(wake_en_q & ~sync_pins);

    // enter on software write, leave at the first edge a wake is seen
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            backup_q <= 1'b0;
        else if (backup_q && wake_hit)
            backup_q <= 1'b0;
        else if (wr_en && wr_addr == REG_BACKUP_OFS && wr_strb[0] && wr_data[BACKUP_ENTER_BIT])
            backup_q <= 1'b1;
    end

    // sticky wake flag, set beats clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            woke_q <= 1'b0;
            wake_pulse_q <= 1'b0;
        end
        else
        begin
            wake_pulse_q <= backup_q & wake_hit;
            if (backup_q && wake_hit)
                woke_q <= 1'b1;
            else if (wr_en && wr_addr == REG_BACKUP_OFS && wr_strb[0]
                && wr_data[BACKUP_WOKE_BIT])
                woke_q <= 1'b0;
        end
    end

    // pins are never driven high
    always_ff @(posedge aclk)
    begin
        pins_out <= '0;
    end

    assign pins_oe_n = oe_n_q;
    assign pullup_en = pullup_q;
    assign timer_count_in = timer_count_in_q;
    assign clk_pair_in = clk_pair_q;
    assign irq_pin_level = irq_level_q;
    assign analog_sel = analog_sel_q;
    assign backup_active = backup_q;
    assign wake_pulse = wake_pulse_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    low_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> (oe_n_q & ~$past(latch_q)) == '0)
        else $error("zero latch bit not driving its pin low");

    shared_live_a: assert property (@(posedge aclk) disable iff (!aresetn)
        alt_q[ALT_CLK_PAIR] |=> oe_n_q[SHARED_PORTD_LINE_A] == $past(latch_q[SHARED_PORTD_LINE_A])
        && oe_n_q[SHARED_PORTD_LINE_B] == $past(latch_q[SHARED_PORTD_LINE_B])
        && oe_n_q[PORT1_BIT3_IRQ_PIN] == $past(latch_q[PORT1_BIT3_IRQ_PIN]))
        else $error("shared line lost its port drive");

    timer_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        alt_q[ALT_TIMER_OUT] |=>
        pin_level_q[PORT1_BIT2_TIMER_PIN] == $past(sync_pins[PORT1_BIT2_TIMER_PIN]))
        else $error("timer pin not readable under timer output");

    analog_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        alt_q[ALT_ANALOG_LSB] |=> oe_n_q[ANALOG_IN_0] == $past(latch_q[ANALOG_IN_0]))
        else $error("analog pin cut from its latch");

    analog_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
        alt_q[ALT_ANALOG_LSB + 3] |=> !pin_level_q[ANALOG_IN_3])
        else $error("analog pin read not masked");

    irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !irq_ctl_q[IRQ_INPUT_GATE_BIT] |=> !irq_level_q)
        else $error("irq pin passed while gated off");

    wake_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        backup_q && wake_hit |=> !backup_q && woke_q && wake_pulse_q)
        else $error("back-up not left on wake");

    port_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        analog_mask == '0 |=> pin_level_q == $past(sync_pins))
        else $error("port read not from pin levels");

    backup_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
        !backup_q ##1 backup_q ##[1:20] !backup_q);
    bitop_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) bitop_hit);
    timer_out_c: cover property (@(posedge aclk) disable iff (!aresetn)
        alt_q[ALT_TIMER_OUT] && !timer_out_val);

endmodule

`default_nettype wire

// ===== verif/gpsp_ext_pins.sv
`default_nettype none

module gpsp_ext_pins (
    input wire logic [17:0] oe_n,
    input wire logic [17:0] pull_en,
    input wire logic [17:0] drv_en,
    input wire logic [17:0] drv_val,
    output logic [17:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    // device pulls low first, then the switch, then the pull-up; an open pin settles low
    always_comb
    begin
        level = oe_n & ((drv_en & drv_val) | (~drv_en & pull_en));
    end
endmodule

`default_nettype wire

// ===== verif/gpsp_shared_io_tb.sv
`default_nettype none

module gpsp_shared_io_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import gpsp_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, timer_out_val, timer_count_in, irq_pin_level, backup_active;
    logic wake_pulse;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
    logic [3:0] s_axi_wstrb, analog_sel;
    logic [1:0] s_axi_bresp, s_axi_rresp, clk_pair_in;
    gpsp_pins_t pins_in, pins_out, pins_oe_n, pullup_en;
    logic [17:0] drv_en, drv_val, lat;
    int fails = 0;
    int n_checks = 0;

    gpsp_shared_io dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_in, .pins_out, .pins_oe_n,
        .pullup_en, .timer_out_val, .timer_count_in, .clk_pair_in, .irq_pin_level,
        .analog_sel, .backup_active, .wake_pulse);
    gpsp_ext_pins ext_u (.oe_n(pins_oe_n), .pull_en(pullup_en), .drv_en(drv_en),
        .drv_val(drv_val), .level(pins_in));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // level seen at a pin: low latch wins over the outside
    function automatic logic [31:0] exp_lvl(input logic [17:0] l, input logic [17:0] e);
        return {14'h0000, l & e};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        fails++;
        end_sim();
    end
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        timer_out_val = 1'b1;
        drv_en = 18'h3FFFF;
        drv_val = 18'h00000;
        seed = 32'h0000DDC8;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        bus_rd(REG_IRQ_CONTROL_OFS, d);
        chk(d, 32'h00000000);
        for (int i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            drv_val <= seed[17:0];
            lat = (i == 5) ? 18'h3FFFF : seed[31:14];
            bus_wr(REG_LATCH_OFS, {14'h0000, lat});
            repeat (4) @(posedge aclk);
            chk(pins_oe_n, lat);
            bus_rd(REG_PIN_LEVEL_OFS, d);
            chk(d, exp_lvl(lat, drv_val));
        end
        bus_wr(REG_ALT_SEL_OFS, 32'h00000007);
        repeat (4) @(posedge aclk);
        chk(timer_count_in, drv_val[6]);
        chk(clk_pair_in, drv_val[15:14]);
        bus_rd(REG_PIN_LEVEL_OFS, d);
        chk(d, exp_lvl(18'h3FFFF, drv_val));
        timer_out_val <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(pins_oe_n[6], 1'b0);
        bus_rd(REG_PIN_LEVEL_OFS, d);
        chk(d[6], 1'b0);
        timer_out_val <= 1'b1;
        bus_wr(REG_BIT_OP_OFS, 32'h00000003);
        repeat (2) @(posedge aclk);
        chk(pins_oe_n[15], 1'b0);
        bus_wr(REG_ALT_SEL_OFS, 32'h000000F0);
        bus_wr(REG_LATCH_OFS, 32'h0003FFFB);
        repeat (2) @(posedge aclk);
        chk({analog_sel, pins_oe_n[2]}, 5'h1E);
        drv_val <= 18'h00080;
        bus_wr(REG_LATCH_OFS, 32'h0003FFFF);
        repeat (4) @(posedge aclk);
        chk(irq_pin_level, 1'b0);
        bus_wr(REG_IRQ_CONTROL_OFS, 32'h00000008);
        repeat (4) @(posedge aclk);
        chk(irq_pin_level, 1'b1);
        drv_en <= 18'h3FF7F;
        bus_wr(REG_WAKE_EN_OFS, 32'h00000080);
        bus_wr(REG_BACKUP_OFS, 32'h00000001);
        repeat (4) @(posedge aclk);
        bus_rd(REG_BACKUP_OFS, d);
        chk(d, 32'h00000002);
        // pulled-up wake pin holds back-up until driven low
        bus_wr(REG_PULLUP_OFS, 32'h00000080);
        bus_wr(REG_BACKUP_OFS, 32'h00000003);
        repeat (2) @(posedge aclk);
        bus_rd(REG_BACKUP_OFS, d);
        chk(d, 32'h00000001);
        chk(pullup_en, 32'h00000080);
        drv_en <= 18'h3FFFF;
        drv_val <= 18'h00000;
        repeat (4) @(posedge aclk);
        chk({wake_pulse, backup_active}, 32'h00000002);
        // no wake source: irq control cleared before back-up
        bus_wr(REG_WAKE_EN_OFS, 32'h00000000);
        bus_wr(REG_IRQ_CONTROL_OFS, 32'h00000000);
        bus_wr(REG_BACKUP_OFS, 32'h00000001);
        repeat (4) @(posedge aclk);
        chk({pins_out, irq_pin_level, backup_active}, 32'h00000001);
        end_sim();
    end
endmodule

`default_nettype wire
